/* File: rtl/async_sync_converter.sv */
`timescale 1ns/100ps
module async_sync_converter #(
  parameter int BAUD_DIV = modem_timing_pkg::BAUD_DIV_CYCLES
) (
  // clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // asynchronous side
  input wire logic i_async_rx,
  output logic o_async_tx,
  output logic o_flow_hold,
  output logic o_overrun,
  // synchronous channel side
  input wire logic i_exchange,
  input wire logic i_sync_rx_bit,
  output logic o_sync_tx_bit
);

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } rx_state_t;

  rx_state_t st_q, st_d;
  logic [31:0] baud_q, baud_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] char_q, char_d;
  logic [9:0] sh_q, sh_d;
  logic [3:0] left_q, left_d;
  logic tx_q, tx_d, async_q, async_d, ovr_q, ovr_d;

  // async receiver plus one-bit-per-frame shifter onto the sync channel
  always_comb begin
    st_d = st_q;
    baud_d = baud_q;
    bit_d = bit_q;
    char_d = char_q;
    sh_d = sh_q;
    left_d = left_q;
    tx_d = tx_q;
    async_d = async_q;
    ovr_d = ovr_q;
    if (baud_q != 32'h0) begin
      baud_d = baud_q - 32'h1;
    end
    unique case (st_q)
      RX_IDLE: begin
        if (!i_async_rx) begin
          st_d = RX_START;
          baud_d = 32'(BAUD_DIV / 2);
        end
      end
      RX_START: begin
        if (baud_q == 32'h0) begin
          st_d = i_async_rx ? RX_IDLE : RX_DATA; // glitch rejection
          baud_d = 32'(BAUD_DIV - 1);
          bit_d = 3'h0;
        end
      end
      RX_DATA: begin
        if (baud_q == 32'h0) begin
          char_d = {i_async_rx, char_q[7:1]}; // lsb first
          baud_d = 32'(BAUD_DIV - 1);
          bit_d = bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            st_d = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (baud_q == 32'h0) begin
          st_d = RX_IDLE;
          if (i_async_rx && left_q == 4'h0) begin
            sh_d = {1'b1, char_q, 1'b0}; // [RQ13]
            left_d = modem_timing_pkg::CHAR_BITS;
          end else if (i_async_rx) begin
            ovr_d = 1'b1; // channel still busy
          end
        end
      end
    endcase
    // one bit each way per frame exchange
    if (i_exchange) begin
      tx_d = (left_q != 4'h0) ? sh_q[0] : 1'b1; // [RQ13]
      if (left_q != 4'h0) begin
        sh_d = {1'b1, sh_q[9:1]};
        left_d = left_q - 4'h1;
      end
      async_d = i_sync_rx_bit; // [RQ15]
    end
  end

  // state registers
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= RX_IDLE;
      baud_q <= 32'h0;
      bit_q <= 3'h0;
      char_q <= 8'h00;
      sh_q <= modem_timing_pkg::SHIFT_IDLE;
      left_q <= 4'h0;
      tx_q <= 1'b1;
      async_q <= 1'b1;
      ovr_q <= 1'b0;
    end else if (i_ce) begin
      st_q <= st_d;
      baud_q <= baud_d;
      bit_q <= bit_d;
      char_q <= char_d;
      sh_q <= sh_d;
      left_q <= left_d;
      tx_q <= tx_d;
      async_q <= async_d;
      ovr_q <= ovr_d;
    end
  end

  assign o_sync_tx_bit = tx_q;
  assign o_async_tx = async_q;
  assign o_overrun = ovr_q;
  assign o_flow_hold = (left_q != 4'h0); // [RQ14]

endmodule // async_sync_converter

/* File: rtl/modem_frame_timing.sv */
`timescale 1ns/100ps
// Overview of operation
// [RQ1] master clock divided by two gives the 2.048 MHz transport clock
// [RQ2] a divider chain on the transport clock makes the 8 kHz frame sync
// [RQ3] the frame sync also enables codec and converter transfers
// [RQ4] voice moves as 8-bit packets framed by sync high
// [RQ5] sync high lasts exactly eight transport periods per frame
// [RQ6] voice bits launch on transport rising edges while sync high
// [RQ7] voice bits are captured on transport falling edges while sync high
// [RQ8] data and signalling bits swap with the loop at sync rise
// [RQ9] data bit swaps with the converter at sync fall
// [RQ10] converter clock mode is held low by the outside logic
// [RQ11] converter data output floats when its output control asks
// [RQ12] transceiver data output floats under its select enable
// [RQ13] async data up to 9600 baud becomes the 8 kbps channel
// [RQ14] outside must throttle async data faster than the channel
// [RQ15] received channel data is rebuilt as async output meanwhile
// [RQ16] terminal end makes master clock and transmit sync itself
// [RQ17] terminal end gives a receive sync roughly inverse to transmit
// [RQ18] terminal end gives a 128 kHz data clock
// [RQ19] terminal converter uses transmit sync and oscillator tap
// [RQ20] received signalling bit drives the sounder at ringing cadence
// [RQ21] each burst carries eight voice, one signalling, one data bit
// [RQ22] sync high starts on a transport rising edge
module modem_frame_timing #(
  parameter int BAUD_DIV = modem_timing_pkg::BAUD_DIV_CYCLES
) (
  // clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // straps and pin controls
  input wire logic i_terminal_mode,
  input wire logic i_converter_clock_mode,
  input wire logic i_converter_output_control,
  input wire logic i_select_enable_tristate,
  // generated clocks and syncs
  output logic o_oscillator_output_tap,
  output logic o_codec_transceiver_clock_in,
  output logic o_master_frame_sync_in,
  output logic o_transmit_frame_sync,
  output logic o_receive_frame_sync,
  output logic o_data_clock,
  // voice path
  input wire logic [7:0] i_tx_sample,
  input wire logic i_voice_in,
  output logic o_voice_out,
  output logic [7:0] o_rx_sample,
  output logic o_rx_sample_valid,
  // loop side data and signalling bits
  input wire modem_timing_pkg::loop_bits_t i_loop_rx,
  input wire logic i_hook_status,
  output modem_timing_pkg::loop_bits_t o_loop_tx,
  output logic o_loop_data_oe_n,
  // converter side
  input wire logic i_async_rx,
  output logic o_async_tx,
  output logic o_async_oe_n,
  output logic o_flow_hold,
  output logic o_overrun,
  // ringer
  output logic o_sounder
);

  // timing chain state
  logic [modem_timing_pkg::NCO_BITS-1:0] nco_q, nco_d;
  logic mclk_q, mclk_d, tclk_q, tclk_d;
  logic [modem_timing_pkg::SLOT_BITS-1:0] slot_q, slot_d;
  logic sync_q, sync_d, rsync_q, rsync_d, dclk_q, dclk_d;
  logic [modem_timing_pkg::NCO_BITS:0] nco_sum;
  logic m_rise, tp_rise, tp_fall, sync_rise, sync_fall;

  // frame sync is high in the first slots of the frame
  function automatic logic in_sync_window(
    input logic [modem_timing_pkg::SLOT_BITS-1:0] slot);
    in_sync_window = slot < modem_timing_pkg::SYNC_HIGH_SLOTS;
  endfunction

  // master clock from accumulator, halved, then counted into frames
  always_comb begin
    nco_sum = {1'b0, nco_q} + {1'b0, modem_timing_pkg::NCO_INC};
    nco_d = nco_sum[modem_timing_pkg::NCO_BITS-1:0];
    m_rise = nco_sum[modem_timing_pkg::NCO_BITS] && !mclk_q;
    tp_rise = m_rise && !tclk_q;
    tp_fall = m_rise && tclk_q;
    sync_rise = tp_rise && (slot_q == modem_timing_pkg::SLOT_LAST);
    sync_fall = tp_rise
      && (slot_q == modem_timing_pkg::SYNC_HIGH_SLOTS - 8'h01);
    mclk_d = mclk_q ^ nco_sum[modem_timing_pkg::NCO_BITS]; // [RQ16]
    tclk_d = m_rise ? !tclk_q : tclk_q; // [RQ1]
    slot_d = tp_rise ? slot_q + 8'h01 : slot_q; // [RQ2]
    sync_d = in_sync_window(slot_d); // [RQ5] [RQ22]
    rsync_d = i_terminal_mode && !sync_d; // [RQ17]
    dclk_d = i_terminal_mode
      && slot_d[modem_timing_pkg::DATA_CLK_BIT]; // [RQ18]
  end

  // timing chain registers
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nco_q <= modem_timing_pkg::NCO_RESET;
      mclk_q <= 1'b0;
      tclk_q <= 1'b0;
      slot_q <= modem_timing_pkg::SLOT_RESET;
      sync_q <= 1'b0;
      rsync_q <= 1'b0;
      dclk_q <= 1'b0;
    end else if (i_ce) begin
      nco_q <= nco_d;
      mclk_q <= mclk_d;
      tclk_q <= tclk_d;
      slot_q <= slot_d;
      sync_q <= sync_d;
      rsync_q <= rsync_d;
      dclk_q <= dclk_d;
    end
  end

  // voice serialiser and deserialiser
  logic [7:0] txs_q, txs_d, rxs_q, rxs_d, rxo_q, rxo_d;
  logic vout_q, vout_d, rxv_q, rxv_d;

  always_comb begin
    txs_d = txs_q;
    rxs_d = rxs_q;
    rxo_d = rxo_q;
    vout_d = vout_q;
    rxv_d = 1'b0;
    if (sync_rise) begin
      txs_d = i_tx_sample; // [RQ4]
    end
    if (tp_rise && in_sync_window(slot_d)) begin
      vout_d = sync_rise ? i_tx_sample[7]
        : txs_q[3'h7 - slot_d[2:0]]; // [RQ6]
    end
    if (tp_fall && sync_q) begin
      rxs_d = {rxs_q[6:0], i_voice_in}; // [RQ7]
      if (slot_q[2:0] == 3'h7) begin
        rxo_d = {rxs_q[6:0], i_voice_in}; // [RQ4]
        rxv_d = 1'b1;
      end
    end
  end

  // voice registers
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      txs_q <= 8'h00;
      rxs_q <= 8'h00;
      rxo_q <= 8'h00;
      vout_q <= 1'b0;
      rxv_q <= 1'b0;
    end else if (i_ce) begin
      txs_q <= txs_d;
      rxs_q <= rxs_d;
      rxo_q <= rxo_d;
      vout_q <= vout_d;
      rxv_q <= rxv_d;
    end
  end

  // per-frame data and signalling exchange
  modem_timing_pkg::loop_bits_t lrx_q, lrx_d, ltx_q, ltx_d;
  logic snd_q, snd_d, loe_n_q, loe_n_d, aoe_n_q, aoe_n_d;
  logic conv_xchg, conv_tx_bit;

  always_comb begin
    // clock mode low selects the falling sync edge
    conv_xchg = i_converter_clock_mode ? sync_rise : sync_fall; // [RQ10]
    lrx_d = lrx_q;
    ltx_d = ltx_q;
    snd_d = snd_q;
    if (sync_rise) begin
      lrx_d = i_loop_rx; // [RQ8] [RQ21]
      ltx_d.sig = i_hook_status; // [RQ8]
      ltx_d.data = conv_tx_bit; // [RQ8] [RQ3]
      snd_d = i_loop_rx.sig; // [RQ20]
    end
    loe_n_d = i_select_enable_tristate; // [RQ12]
    aoe_n_d = i_converter_output_control; // [RQ11]
  end

  // exchange registers
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lrx_q <= modem_timing_pkg::LOOP_BITS_IDLE;
      ltx_q <= modem_timing_pkg::LOOP_BITS_IDLE;
      snd_q <= 1'b0;
      loe_n_q <= 1'b1;
      aoe_n_q <= 1'b1;
    end else if (i_ce) begin
      lrx_q <= lrx_d;
      ltx_q <= ltx_d;
      snd_q <= snd_d;
      loe_n_q <= loe_n_d;
      aoe_n_q <= aoe_n_d;
    end
  end

  // async to sync converter, one data bit per frame
  async_sync_converter #(
    .BAUD_DIV(BAUD_DIV)
  ) u_conv (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_async_rx(i_async_rx),
    .o_async_tx(o_async_tx),
    .o_flow_hold(o_flow_hold),
    .o_overrun(o_overrun),
    .i_exchange(conv_xchg), // [RQ9] [RQ3]
    .i_sync_rx_bit(lrx_q.data),
    .o_sync_tx_bit(conv_tx_bit)
  );

  // outputs straight from flip-flops
  assign o_oscillator_output_tap = mclk_q;
  assign o_codec_transceiver_clock_in = tclk_q;
  assign o_master_frame_sync_in = sync_q;
  assign o_transmit_frame_sync = sync_q;
  assign o_receive_frame_sync = rsync_q;
  assign o_data_clock = dclk_q;
  assign o_voice_out = vout_q;
  assign o_rx_sample = rxo_q;
  assign o_rx_sample_valid = rxv_q;
  assign o_loop_tx = ltx_q;
  assign o_loop_data_oe_n = loe_n_q;
  assign o_async_oe_n = aoe_n_q;
  assign o_sounder = snd_q;

  // helper: cycles of sync high measured in transport rising edges
  logic [3:0] hi_cnt_q;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hi_cnt_q <= 4'h0;
    end else if (i_ce && tp_rise) begin
      hi_cnt_q <= sync_q ? hi_cnt_q + 4'h1 : 4'h0;
    end
  end

  chk_transport_halves_master: assert property ( // [RQ1]
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && m_rise |=> tclk_q != $past(tclk_q))
    else $error("transport clock did not toggle on master rise");

  chk_sync_after_frame: assert property ( // [RQ2]
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && sync_rise |=> sync_q && slot_q == 8'h00)
    else $error("sync did not rise at frame start");

  chk_sync_high_eight: assert property ( // [RQ5]
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && sync_fall |=> !sync_q && hi_cnt_q == 4'h8)
    else $error("sync high phase not eight transport periods");

  chk_sync_on_rising: assert property ( // [RQ22]
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(sync_q) |-> tclk_q && $past(!tclk_q))
    else $error("sync rose away from a transport rising edge");

  chk_voice_launch_msb: assert property ( // [RQ6]
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && sync_rise |=> vout_q == $past(i_tx_sample[7]))
    else $error("first voice bit is not the sample msb");

  chk_voice_capture_eight: assert property ( // [RQ7]
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    rxv_q |-> $past(tp_fall) && !tclk_q && rxo_q[0] == $past(i_voice_in))
    else $error("voice sample not completed on a falling edge");

  chk_loop_swap_rise: assert property ( // [RQ8]
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && sync_rise |=> lrx_q == $past(i_loop_rx)
      && ltx_q.sig == $past(i_hook_status))
    else $error("loop bits not swapped at sync rise");

  chk_sounder_follows_sig: assert property ( // [RQ20]
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    snd_q != $past(snd_q) |-> $past(sync_rise) && snd_q == lrx_q.sig)
    else $error("sounder changed outside a frame exchange");

  chk_receive_inverse: assert property ( // [RQ17]
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && i_terminal_mode |=> rsync_q == !sync_q)
    else $error("receive sync not inverse of transmit sync");

  chk_tristate_controls: assert property ( // [RQ11]
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce |=> aoe_n_q == $past(i_converter_output_control)
      && loe_n_q == $past(i_select_enable_tristate))
    else $error("output enables do not follow their controls");

endmodule // modem_frame_timing

/* File: shared/modem_timing_pkg.sv */
package modem_timing_pkg;

  // clock rates of the timing chain
  localparam longint CLK_HZ = 125_000_000;
  localparam longint MASTER_HZ = 4_096_000;
  localparam longint TRANSPORT_HZ = MASTER_HZ / 2;
  localparam longint FRAME_HZ = 8_000;
  localparam longint DATA_CLK_HZ = 128_000;
  localparam longint BAUD_RATE = 9_600;

  // phase accumulator that makes the master clock half periods
  localparam int NCO_BITS = 24;
  localparam logic [NCO_BITS-1:0] NCO_INC =
    NCO_BITS'(((2 * MASTER_HZ) << NCO_BITS) / CLK_HZ);
  localparam logic [NCO_BITS-1:0] NCO_RESET = 24'h000000;

  // frame layout in transport clock periods
  localparam int SLOTS_PER_FRAME = int'(TRANSPORT_HZ / FRAME_HZ);
  localparam int SLOT_BITS = $clog2(SLOTS_PER_FRAME);
  localparam logic [SLOT_BITS-1:0] SLOT_LAST = SLOT_BITS'(SLOTS_PER_FRAME - 1);
  localparam logic [SLOT_BITS-1:0] SYNC_HIGH_SLOTS = 8'h08;
  localparam logic [SLOT_BITS-1:0] SLOT_RESET = SLOT_LAST;
  localparam int VOICE_BITS = 8;
  localparam int DATA_CLK_BIT = $clog2(int'(TRANSPORT_HZ / DATA_CLK_HZ)) - 1;

  // async character: start, eight data bits, stop
  localparam int BAUD_DIV_CYCLES = int'(CLK_HZ / BAUD_RATE);
  localparam logic [3:0] CHAR_BITS = 4'ha;
  localparam logic [9:0] SHIFT_IDLE = 10'h3ff;

  // bits carried once per frame beside the voice sample
  typedef struct packed {
    logic sig;
    logic data;
  } loop_bits_t;

  localparam loop_bits_t LOOP_BITS_IDLE = 2'h3;

endpackage

/* File: tb/loop_codec_model.sv */
`timescale 1ns/100ps
// behavioural voice side of the codec and loop transceiver
module loop_codec_model (
  // clock and timing seen from the block
  input wire logic i_clk_sys,
  input wire logic i_tclk,
  input wire logic i_sync,
  // voice lines
  input wire logic i_voice_out,
  input wire logic [7:0] i_pattern,
  output logic o_voice_in,
  output logic [7:0] o_captured
);
  logic tclk_prev;
  logic sync_prev;
  logic [2:0] bit_idx;

  initial begin
    tclk_prev = 1'b0;
    sync_prev = 1'b0;
    bit_idx = 3'h0;
    o_voice_in = 1'b0;
    o_captured = 8'h00;
  end

  // launch on transport rise in sync high, capture on transport fall
  always @(negedge i_clk_sys) begin
    if (i_sync && !sync_prev) begin
      bit_idx = 3'h6;
      o_voice_in <= i_pattern[7];
    end else if (i_sync && i_tclk && !tclk_prev) begin
      o_voice_in <= i_pattern[bit_idx];
      bit_idx = bit_idx - 3'h1;
    end else if (!i_sync) begin
      o_voice_in <= ~o_voice_in; // released line keeps no value
    end
    if (i_sync && !i_tclk && tclk_prev)
      o_captured <= {o_captured[6:0], i_voice_out};
    tclk_prev = i_tclk;
    sync_prev = i_sync;
  end
endmodule // loop_codec_model

/* File: tb/modem_frame_timing_tb_top.sv */
`timescale 1ns/100ps
// self-checking bench for the frame timing block
module modem_frame_timing_tb_top;
  localparam int BAUD = 16;
  logic clk, rst_n, term, oc, se, hook, arx;
  logic [7:0] tx_sample, pattern, captured, rx_sample;
  modem_timing_pkg::loop_bits_t loop_rx, loop_tx;
  logic mclk, tclk, sync, tsync, rsync, dclk, vout, vin, rx_valid;
  logic loop_oe_n, atx, aoe_n, flow, ovr, sounder, ce;
  int fails = 0;
  int n_compared = 0;

  modem_frame_timing #(.BAUD_DIV(BAUD)) i_dut (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(ce),
    .i_terminal_mode(term),
    .i_converter_clock_mode(1'b0),
    .i_converter_output_control(oc), .i_select_enable_tristate(se),
    .o_oscillator_output_tap(mclk), .o_codec_transceiver_clock_in(tclk),
    .o_master_frame_sync_in(sync), .o_transmit_frame_sync(tsync),
    .o_receive_frame_sync(rsync), .o_data_clock(dclk),
    .i_tx_sample(tx_sample), .i_voice_in(vin), .o_voice_out(vout),
    .o_rx_sample(rx_sample), .o_rx_sample_valid(rx_valid),
    .i_loop_rx(loop_rx), .i_hook_status(hook), .o_loop_tx(loop_tx),
    .o_loop_data_oe_n(loop_oe_n), .i_async_rx(arx), .o_async_tx(atx),
    .o_async_oe_n(aoe_n), .o_flow_hold(flow), .o_overrun(ovr),
    .o_sounder(sounder));

  loop_codec_model i_codec (
    .i_clk_sys(clk), .i_tclk(tclk), .i_sync(sync), .i_voice_out(vout),
    .i_pattern(pattern), .o_voice_in(vin), .o_captured(captured));

  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // wait for a sync level, bounded by a little over one frame
  task automatic wait_sync(input logic lvl);
    int n;
    n = 0;
    while (sync !== lvl && n < 20000) begin
      @(negedge clk);
      n++;
    end
    check(sync, lvl, "sync wait");
  endtask

  // one asynchronous 8N1 character
  task automatic send_char(input logic [7:0] ch);
    logic [9:0] fr;
    fr = {1'b1, ch, 1'b0};
    for (int i = 0; i < 10; i++) begin
      arx = fr[i];
      repeat (BAUD) @(negedge clk);
    end
  endtask

  task automatic test_reset();
    check({tclk, mclk, sync, vout, rsync, dclk}, 16'h0, "clocks in reset");
    check(loop_tx, 16'h3, "loop bits idle in reset");
    check({loop_oe_n, aoe_n, atx, flow, ovr, sounder}, 16'h38, "pins reset");
    $display("test_reset done");
  endtask

  // one whole frame counted edge by edge, terminal outputs on
  task automatic test_clocks();
    int cyc, t_up, t_hi, m_up, d_up, bad_r, bad_t;
    logic tp, mp, dp, sp;
    term = 1'b1;
    wait_sync(1'b0);
    wait_sync(1'b1);
    check(tclk, 1'b1, "sync high starts with transport high");
    {cyc, t_up, t_hi, m_up, d_up, bad_r, bad_t} = '0;
    {tp, mp, dp, sp} = {tclk, mclk, dclk, sync};
    do begin
      @(negedge clk);
      cyc++;
      if (tclk && !tp) t_up++;
      if (tclk && !tp && sp) t_hi++;
      if (mclk && !mp) m_up++;
      if (dclk && !dp) d_up++;
      if (rsync !== ~sync) bad_r++;
      if (tsync !== sync) bad_t++;
      {tp, mp, dp, sp} = {tclk, mclk, dclk, sync};
    end while (!(sync && cyc > 1000) && cyc < 20000);
    check(cyc >= 15624 && cyc <= 15626, 1'b1, "frame length");
    check(16'(m_up), 16'd512, "master periods per frame");
    check(16'(t_up), 16'd256, "transport periods per frame");
    check(16'(t_hi), 16'd8, "transport periods in sync high");
    check(16'(d_up), 16'd16, "data clock periods per frame");
    check(16'(bad_r), 16'd0, "receive sync inverse");
    check(16'(bad_t), 16'd0, "transmit sync follows sync");
    term = 1'b0;
    repeat (3) @(negedge clk);
    check({rsync, dclk}, 16'h0, "terminal outputs off");
    $display("test_clocks done");
  endtask

  // output enables follow their controls one cycle later
  task automatic test_pins();
    logic [5:0] snap;
    // enable low must freeze clocks, syncs and the pin registers
    snap = {mclk, tclk, sync, vout, aoe_n, loop_oe_n};
    ce = 1'b0;
    oc = 1'b0;
    repeat (40) @(negedge clk);
    check({mclk, tclk, sync, vout, aoe_n, loop_oe_n}, snap, "frozen");
    ce = 1'b1;
    {oc, se} = 2'b00;
    @(negedge clk);
    check({aoe_n, loop_oe_n}, 16'h0, "both outputs driven");
    oc = 1'b1;
    @(negedge clk);
    check({aoe_n, loop_oe_n}, 16'h2, "converter output off");
    {oc, se} = 2'b01;
    @(negedge clk);
    check({aoe_n, loop_oe_n}, 16'h1, "loop data output off");
    se = 1'b0;
    $display("test_pins done");
  endtask

  // one voice sample each way
  task automatic test_voice();
    int n;
    wait_sync(1'b0);
    tx_sample = 8'ha5;
    pattern = 8'h3c;
    wait_sync(1'b1);
    check(vout, 1'b1, "msb leads the packet");
    n = 0;
    while (rx_valid !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    check(rx_sample, 16'h3c, "sample from codec");
    check(sync, 1'b1, "capture ends inside sync high");
    @(negedge clk);
    check(rx_valid, 1'b0, "valid lasts one cycle");
    check(captured, 16'ha5, "sample to codec");
    $display("test_voice done");
  endtask

  // signalling at sync rise, data bit at sync fall
  task automatic test_loop();
    wait_sync(1'b0);
    loop_rx = '{sig: 1'b1, data: 1'b0};
    hook = 1'b0;
    wait_sync(1'b1);
    repeat (2) @(negedge clk);
    check(loop_tx.sig, 1'b0, "hook bit to loop");
    check(sounder, 1'b1, "ring bit to sounder");
    check(atx, 1'b1, "async out waits for sync fall");
    hook = 1'b1;
    wait_sync(1'b0);
    repeat (2) @(negedge clk);
    check(atx, 1'b0, "channel bit rebuilt");
    check(loop_tx.sig, 1'b0, "hook bit held for the frame");
    $display("test_loop done");
  endtask

  // character onto the channel, second one overruns
  task automatic test_converter();
    loop_rx = '{sig: 1'b0, data: 1'b1};
    send_char(8'ha5);
    check(flow, 1'b1, "flow hold while busy");
    check(ovr, 1'b0, "no overrun yet");
    send_char(8'h0f);
    check(ovr, 1'b1, "overrun on busy channel");
    wait_sync(1'b1);
    repeat (2) @(negedge clk);
    check(loop_tx.data, 1'b1, "channel idle before exchange");
    check(sounder, 1'b0, "sounder toggles with ring bit");
    wait_sync(1'b0);
    wait_sync(1'b1);
    repeat (2) @(negedge clk);
    check(loop_tx.data, 1'b0, "start bit on channel");
    wait_sync(1'b0);
    wait_sync(1'b1);
    repeat (2) @(negedge clk);
    check(loop_tx.data, 1'b1, "lsb first on channel");
    check(flow, 1'b1, "flow hold until character sent");
    $display("test_converter done");
  endtask

  // clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // watchdog a little beyond the six frames the tests need
  initial begin
    repeat (99000) @(posedge clk);
    fails++;
    results();
  end

  // main sequence
  initial begin
    {rst_n, term, oc, se, hook, arx} = 6'h0f;
    ce = 1'b1;
    tx_sample = 8'h00;
    pattern = 8'h00;
    loop_rx = 2'h3;
    repeat (2) @(negedge clk);
    test_reset();
    @(negedge clk);
    rst_n = 1'b1;
    test_clocks();
    test_pins();
    test_voice();
    test_loop();
    test_converter();
    results();
  end
endmodule // modem_frame_timing_tb_top
